// >>> rtl/tec_defines.svh
// Purpose: Register map constants of the timer channel
// Assumes: Byte addresses, one word per register
// Notes: Definitions only
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH

// Register byte offsets
`define TEC_OFS_CHAN_EN    8'h00
`define TEC_OFS_RUN        8'h04
`define TEC_OFS_CTRL       8'h08
`define TEC_OFS_MODE       8'h0C
`define TEC_OFS_FFCR       8'h10
`define TEC_OFS_STATUS     8'h14
`define TEC_OFS_CMP0       8'h18
`define TEC_OFS_CMP1       8'h1C
`define TEC_OFS_CAP0       8'h20
`define TEC_OFS_CAP1       8'h24
`define TEC_OFS_SNAP       8'h28

// Field positions
`define TEC_BIT_CHAN_EN    0
`define TEC_BIT_RUN        0
`define TEC_BIT_BUF_EN     7
`define TEC_CTRL_TRIG_HI   1
`define TEC_CTRL_TRIG_LO   0
`define TEC_MODE_SRC_HI    2
`define TEC_MODE_SRC_LO    0
`define TEC_BIT_CLE        3
`define TEC_MODE_CPM_HI    5
`define TEC_MODE_CPM_LO    4
`define TEC_BIT_SWCAP      6
`define TEC_FF_CMD_HI      1
`define TEC_FF_CMD_LO      0
`define TEC_BIT_T_M0       2
`define TEC_BIT_T_M1       3
`define TEC_BIT_T_C0       4
`define TEC_BIT_T_C1       5

// Field encodings
`define TEC_SRC_EXT        3'h0
`define TEC_TRIG_EXT       2'h1
`define TEC_CPM_OFF        2'h0
`define TEC_CPM_RISE_FALL  2'h1
`define TEC_CPM_RISE       2'h2
`define TEC_CPM_MATCH      2'h3
`define TEC_FF_INVERT      2'h0
`define TEC_FF_SET         2'h1
`define TEC_FF_CLEAR       2'h2
`define TEC_FF_HOLD        2'h3

// Reset values and counter maximum
`define TEC_RST_MODE       8'h40
`define TEC_RST_CTRL       8'h00
`define TEC_RST_FFCR       6'h00
`define TEC_RST_CNT        16'h0000
`define TEC_CNT_MAX        16'hFFFF

// AXI responses
`define TEC_RESP_OKAY      2'h0
`define TEC_RESP_SLVERR    2'h2

`endif

// >>> rtl/tec_pkg.sv
// Purpose: Types shared by the timer channel
// Assumes: Nothing
// Notes: Constants live in tec_defines.svh
package tec_pkg;

  typedef enum logic [1:0] {
    TEC_STOP  = 2'h0,
    TEC_ARMED = 2'h1,
    TEC_COUNT = 2'h2
  } tec_cnt_state_t;

endpackage : tec_pkg

// >>> rtl/tec_prescaler.sv
// Purpose: Free-running prescaler giving one-cycle count strobes per tap
// Assumes: Select 1..7 pick divide by 1,4,16,32,64,128,256; 0 gives none
// Notes: Strobe is registered
`timescale 1ns/10ps
`include "tec_defines.svh"
module tec_prescaler #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Tap select and strobe
  input wire logic [2:0] tap_sel,
  output logic tick
);

  logic [DIV_W-1:0] div_r;

  function automatic logic [DIV_W-1:0] tec_tap_mask(input logic [2:0] sel);
    case (sel)
      3'h1: tec_tap_mask = DIV_W'(8'h00);
      3'h2: tec_tap_mask = DIV_W'(8'h03);
      3'h3: tec_tap_mask = DIV_W'(8'h0F);
      3'h4: tec_tap_mask = DIV_W'(8'h1F);
      3'h5: tec_tap_mask = DIV_W'(8'h3F);
      3'h6: tec_tap_mask = DIV_W'(8'h7F);
      3'h7: tec_tap_mask = DIV_W'(8'hFF);
      default: tec_tap_mask = DIV_W'(8'h00);
    endcase
  endfunction : tec_tap_mask

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= (tap_sel != `TEC_SRC_EXT) &&
              ((div_r & tec_tap_mask(tap_sel)) == tec_tap_mask(tap_sel));
    end
  end

endmodule : tec_prescaler

// >>> rtl/tec_edge_sync.sv
// Purpose: Two-stage synchroniser with rising and falling edge strobes
// Assumes: Input is asynchronous to aclk
// Notes: Strobes are one cycle, registered
`timescale 1ns/10ps
module tec_edge_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and strobes
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      level <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      level <= sync_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= sync_r && !level;
      fall <= !sync_r && level;
    end
  end

endmodule : tec_edge_sync

// >>> rtl/tec_top.sv
// Purpose: 16-bit timer and event counter channel with AXI4-Lite registers
// Assumes: One clock, synchronous active-low reset
// Notes: Event outputs are one-cycle pulses
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "tec_defines.svh"

// Operation
// - Channel counter is a sixteen-bit binary up-counter.
// - Source select picks a prescaler tap or rising input pin edges.
// - Run bit one counts; run bit zero stops and zeroes counter.
// - Clear-on-match set clears counter at compare 1 match; else free-running.
// - Counter overflow raises the compare-0/overflow event.
// - Two compare registers; match when counter equals either.
// - Shadow buffers, off after reset, load at compare 1 match when enabled.
// - Compare writes act immediately while the counter is stopped.
// - Two-bit capture timing field chooses capture latch events.
// - Writing zero to software capture bit copies counter to capture 0.
// - Snapshot register reads the current counter value.
// - Compare 0 or 1 matches raise their own match events.
// - Toggle flip-flop inverts when an odd number of enabled matches and capture latches coincide.
// - Command field: 00 inverts, 01 sets, 10 clears the flip-flop.
// - Toggle flip-flop drives the timer output pin.
// - Capture events fire when capture 0 or 1 is latched.
// - Event counter mode counts input rising edges; read via software capture.
// - With buffering, buffer 0 loads compare 0 at compare 1 match.
// - Trigger field 01 starts counting on a rising input pin edge.
module tec_top #(
  parameter int CNT_W = 16,
  parameter int PRESC_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  // Events
  output logic match0_overflow_irq,
  output logic match1_irq,
  output logic capture0_irq,
  output logic capture1_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic chan_en_r;
  logic run_bit_r;
  logic [7:0] control_register_r;
  logic [7:0] mode_register_r;
  logic [5:0] ffcr_r;
  logic [CNT_W-1:0] count_register_r;
  logic [CNT_W-1:0] compare_reg_0_r;
  logic [CNT_W-1:0] compare_reg_1_r;
  logic [CNT_W-1:0] buf0_r;
  logic [CNT_W-1:0] buf1_r;
  logic [CNT_W-1:0] capture_reg_0_r;
  logic [CNT_W-1:0] capture_reg_1_r;
  logic toggle_flipflop_r;
  tec_pkg::tec_cnt_state_t state_r;
  tec_pkg::tec_cnt_state_t state_nxt;
  logic [CNT_W-1:0] count_nxt;

  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  logic wr_go;
  logic rd_go;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;

  logic presc_tick;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  logic [2:0] count_source_select;
  logic clear_on_match_bit;
  logic [1:0] capture_timing_field;
  logic buffer_enable_bit;
  logic [1:0] trig_field;
  logic cnt_tick;
  logic cnt_en;
  logic comparator_a;
  logic comparator_b;
  logic m0_ev;
  logic m1_ev;
  logic ovf_ev;
  logic sw_cap;
  logic cap0_ev;
  logic cap1_ev;
  logic toggle_ev;
  logic wr_cmp0;
  logic wr_cmp1;
  logic wr_ffcr;
  logic [1:0] flipflop_command_field;

  function automatic logic [CNT_W-1:0] tec_merge(input logic [CNT_W-1:0] old_v,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
    tec_merge = old_v;
    if (strb[0]) tec_merge[7:0] = data[7:0];
    if (strb[1]) tec_merge[CNT_W-1:8] = data[CNT_W-1:8];
  endfunction : tec_merge

  function automatic logic tec_wr_hit(input logic go, input logic [7:0] addr,
                                      input logic [7:0] ofs);
    tec_wr_hit = go && (addr == ofs);
  endfunction : tec_wr_hit

  ////////////////////////////////////////////////////////////////////////////////
  // Count strobe sources

  assign count_source_select = mode_register_r[`TEC_MODE_SRC_HI:`TEC_MODE_SRC_LO];
  assign clear_on_match_bit = mode_register_r[`TEC_BIT_CLE];
  assign capture_timing_field = mode_register_r[`TEC_MODE_CPM_HI:`TEC_MODE_CPM_LO];
  assign buffer_enable_bit = control_register_r[`TEC_BIT_BUF_EN];
  assign trig_field = control_register_r[`TEC_CTRL_TRIG_HI:`TEC_CTRL_TRIG_LO];

  tec_prescaler #(
    .DIV_W(PRESC_W)
  ) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .tap_sel(count_source_select),
    .tick(presc_tick)
  );

  tec_edge_sync u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(timer_input_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cnt_tick = (count_source_select == `TEC_SRC_EXT) ? pin_rise : presc_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  assign wr_err = (s_axi_awaddr[1:0] != 2'h0) || (s_axi_awaddr > `TEC_OFS_SNAP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `TEC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_err ? `TEC_RESP_SLVERR : `TEC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `TEC_OFS_CHAN_EN: rd_data[`TEC_BIT_CHAN_EN] = chan_en_r;
      `TEC_OFS_RUN: rd_data[`TEC_BIT_RUN] = run_bit_r;
      `TEC_OFS_CTRL: rd_data[7:0] = control_register_r;
      `TEC_OFS_MODE: rd_data[7:0] = mode_register_r;
      `TEC_OFS_FFCR: rd_data[5:0] = {ffcr_r[5:2], `TEC_FF_HOLD};
      `TEC_OFS_STATUS: rd_data[3:0] = {pin_level, state_r, toggle_flipflop_r};
      `TEC_OFS_CMP0: rd_data[CNT_W-1:0] = compare_reg_0_r;
      `TEC_OFS_CMP1: rd_data[CNT_W-1:0] = compare_reg_1_r;
      `TEC_OFS_CAP0: rd_data[CNT_W-1:0] = capture_reg_0_r;
      `TEC_OFS_CAP1: rd_data[CNT_W-1:0] = capture_reg_1_r;
      `TEC_OFS_SNAP: rd_data[CNT_W-1:0] = count_register_r;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= `TEC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_err ? `TEC_RESP_SLVERR : `TEC_RESP_OKAY;
      rdata_r <= rd_data;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  assign wr_cmp0 = tec_wr_hit(wr_go, s_axi_awaddr, `TEC_OFS_CMP0);
  assign wr_cmp1 = tec_wr_hit(wr_go, s_axi_awaddr, `TEC_OFS_CMP1);
  assign wr_ffcr = tec_wr_hit(wr_go, s_axi_awaddr, `TEC_OFS_FFCR) && s_axi_wstrb[0];
  assign flipflop_command_field = s_axi_wdata[`TEC_FF_CMD_HI:`TEC_FF_CMD_LO];
  assign sw_cap = tec_wr_hit(wr_go, s_axi_awaddr, `TEC_OFS_MODE) && s_axi_wstrb[0] &&
                  !s_axi_wdata[`TEC_BIT_SWCAP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_en_r <= 1'b0;
      run_bit_r <= 1'b0;
      control_register_r <= `TEC_RST_CTRL;
      mode_register_r <= `TEC_RST_MODE;
      ffcr_r <= `TEC_RST_FFCR;
    end else if (wr_go && s_axi_wstrb[0]) begin
      case (s_axi_awaddr)
        `TEC_OFS_CHAN_EN: chan_en_r <= s_axi_wdata[`TEC_BIT_CHAN_EN];
        `TEC_OFS_RUN: run_bit_r <= s_axi_wdata[`TEC_BIT_RUN];
        `TEC_OFS_CTRL: control_register_r <= s_axi_wdata[7:0];
        `TEC_OFS_MODE: mode_register_r <= s_axi_wdata[7:0];
        `TEC_OFS_FFCR: ffcr_r <= s_axi_wdata[5:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tec_pkg::TEC_STOP: begin
        if (run_bit_r && chan_en_r) begin
          state_nxt = (trig_field == `TEC_TRIG_EXT) ? tec_pkg::TEC_ARMED
                                                    : tec_pkg::TEC_COUNT;
        end
      end
      tec_pkg::TEC_ARMED: begin
        if (pin_rise) begin
          state_nxt = tec_pkg::TEC_COUNT;
        end
      end
      tec_pkg::TEC_COUNT: state_nxt = tec_pkg::TEC_COUNT;
      default: state_nxt = tec_pkg::TEC_STOP;
    endcase
    if (!run_bit_r || !chan_en_r) begin
      state_nxt = tec_pkg::TEC_STOP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= tec_pkg::TEC_STOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cnt_en = (state_r == tec_pkg::TEC_COUNT) && run_bit_r && chan_en_r && cnt_tick;
  assign comparator_a = (count_register_r == compare_reg_0_r);
  assign comparator_b = (count_register_r == compare_reg_1_r);
  assign m0_ev = cnt_en && comparator_a;
  assign m1_ev = cnt_en && comparator_b;
  assign ovf_ev = cnt_en && (count_register_r == `TEC_CNT_MAX) &&
                  !(clear_on_match_bit && comparator_b);

  always_comb begin
    count_nxt = count_register_r;
    if (!run_bit_r) begin
      count_nxt = `TEC_RST_CNT;
    end else if (cnt_en) begin
      if (clear_on_match_bit && comparator_b) begin
        count_nxt = `TEC_RST_CNT;
      end else begin
        count_nxt = count_register_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_register_r <= `TEC_RST_CNT;
    end else begin
      count_register_r <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare registers and shadow buffers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf0_r <= `TEC_RST_CNT;
      buf1_r <= `TEC_RST_CNT;
    end else begin
      if (wr_cmp0) begin
        buf0_r <= tec_merge(buf0_r, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_cmp1) begin
        buf1_r <= tec_merge(buf1_r, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_reg_0_r <= `TEC_RST_CNT;
      compare_reg_1_r <= `TEC_RST_CNT;
    end else if (!buffer_enable_bit || !run_bit_r) begin
      if (wr_cmp0) begin
        compare_reg_0_r <= tec_merge(buf0_r, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_cmp1) begin
        compare_reg_1_r <= tec_merge(buf1_r, s_axi_wdata, s_axi_wstrb);
      end
    end else if (m1_ev) begin
      compare_reg_0_r <= buf0_r;
      compare_reg_1_r <= buf1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture

  always_comb begin
    cap0_ev = sw_cap;
    cap1_ev = 1'b0;
    case (capture_timing_field)
      `TEC_CPM_OFF: cap1_ev = 1'b0;
      `TEC_CPM_RISE_FALL: begin
        cap0_ev = sw_cap || pin_rise;
        cap1_ev = pin_fall;
      end
      `TEC_CPM_RISE: cap0_ev = sw_cap || pin_rise;
      `TEC_CPM_MATCH: begin
        cap0_ev = sw_cap || m0_ev;
        cap1_ev = m1_ev;
      end
      default: cap1_ev = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reg_0_r <= `TEC_RST_CNT;
      capture_reg_1_r <= `TEC_RST_CNT;
    end else begin
      if (cap0_ev) begin
        capture_reg_0_r <= count_register_r;
      end
      if (cap1_ev) begin
        capture_reg_1_r <= count_register_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Toggle flip-flop and events

  assign toggle_ev = (m0_ev && ffcr_r[`TEC_BIT_T_M0]) ^ (m1_ev && ffcr_r[`TEC_BIT_T_M1]) ^
                     (cap0_ev && ffcr_r[`TEC_BIT_T_C0]) ^ (cap1_ev && ffcr_r[`TEC_BIT_T_C1]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_flipflop_r <= 1'b0;
    end else if (wr_ffcr && (flipflop_command_field != `TEC_FF_HOLD)) begin
      case (flipflop_command_field)
        `TEC_FF_INVERT: toggle_flipflop_r <= !toggle_flipflop_r;
        `TEC_FF_SET: toggle_flipflop_r <= 1'b1;
        `TEC_FF_CLEAR: toggle_flipflop_r <= 1'b0;
        default: toggle_flipflop_r <= toggle_flipflop_r;
      endcase
    end else if (toggle_ev) begin
      toggle_flipflop_r <= !toggle_flipflop_r;
    end
  end

  assign timer_output_pin = toggle_flipflop_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match0_overflow_irq <= 1'b0;
      match1_irq <= 1'b0;
      capture0_irq <= 1'b0;
      capture1_irq <= 1'b0;
    end else begin
      match0_overflow_irq <= m0_ev || ovf_ev;
      match1_irq <= m1_ev;
      capture0_irq <= cap0_ev;
      capture1_irq <= cap1_ev;
    end
  end

endmodule : tec_top

// >>> bench/tec_top_asserts.sv
// Purpose: Port-level checks of the timer channel
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into tec_top
`timescale 1ns/10ps
`include "tec_defines.svh"
module tec_top_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and events
  input wire logic timer_input_pin,
  input wire logic timer_output_pin,
  input wire logic match0_overflow_irq,
  input wire logic match1_irq,
  input wire logic capture0_irq,
  input wire logic capture1_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_take;
  logic rd_take;
  logic irq_any;
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && !s_axi_rvalid;
  assign irq_any = match0_overflow_irq || match1_irq || capture0_irq || capture1_irq;
  function automatic logic mapped(input logic [7:0] a);
    return a <= 8'h28 && a[1:0] == 2'h0;
  endfunction : mapped
  wr_resp_next_a: assert property (wr_take |=> s_axi_bvalid && s_axi_bresp ==
    (mapped($past(s_axi_awaddr)) ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR))
    else $error("bad write response");
  wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rd_resp_next_a: assert property (rd_take |=> s_axi_rvalid && (mapped($past(s_axi_araddr))
    ? s_axi_rresp == `TEC_RESP_OKAY : s_axi_rresp == `TEC_RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("bad read response");
  rd_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
  ready_terms_a: assert property (s_axi_awready == wr_take && s_axi_arready == rd_take)
    else $error("ready term wrong");
  quiet_reset_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid &&
    !s_axi_rvalid && !irq_any && !timer_output_pin) else $error("output active in reset");
  pin_cause_a: assert property ($changed(timer_output_pin) |-> irq_any ||
    $past(irq_any) || $past(wr_take) || $past(wr_take, 2)) else $error("output pin moved alone");
  cap1_cause_a: assert property (capture1_irq |-> match1_irq || $past(match1_irq) ||
    !$past(timer_input_pin, 3) || !$past(timer_input_pin, 4) || !$past(timer_input_pin, 5))
    else $error("capture 1 uncaused");
  match1_cov: cover property (match1_irq);
  cap1_cov: cover property (capture1_irq);
  slverr_cov: cover property (s_axi_bvalid && s_axi_bresp == `TEC_RESP_SLVERR);
endmodule : tec_top_asserts

bind tec_top tec_top_asserts u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_input_pin(timer_input_pin),
  .timer_output_pin(timer_output_pin), .match0_overflow_irq(match0_overflow_irq),
  .match1_irq(match1_irq), .capture0_irq(capture0_irq), .capture1_irq(capture1_irq));

// >>> bench/tec_pin_model.sv
// Purpose: Drives the external event pin of the timer channel
// Assumes: Pin sampled asynchronously
// Notes: Levels change just after a rising edge
`timescale 1ns/10ps
module tec_pin_model (
  // Clock
  input wire logic aclk,
  // Event pin
  output logic pin
);
  initial pin = 1'b0;
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      pin <= 1'b1;
      repeat (hi) @(posedge aclk);
      pin <= 1'b0;
      repeat (lo) @(posedge aclk);
    end
  endtask : pulses
endmodule : tec_pin_model

// >>> bench/tb_top.sv
// Purpose: Self-checking bench of the timer channel
// Assumes: Register map of the channel
// Notes: Bus results are queued and checked by the monitor
`timescale 1ns/10ps
`include "tec_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_in, pin_out, m0, m1, cp0, cp1;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_q[$], msk_q[$], got, e, m;
  logic [31:0] seed = 32'h28;
  int miscompares = 0, n_compared = 0, cyc = 0, n_cap0 = 0, n_cap1 = 0;
  int n, a, k, t0, t1, t2;
  logic [7:0] ra [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h28};
  logic [31:0] re [7] = '{32'h0, 32'h0, 32'h40, 32'h3, 32'h0, 32'h0, 32'h0};
  logic [31:0] rm [7] = '{32'h1, 32'hFF, 32'hFF, 32'h3F, 32'h7, 32'hFFFF, 32'hFFFF};
  always #4 aclk = ~aclk;
  tec_pin_model u_pin (.aclk(aclk), .pin(pin_in));
  tec_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(s_axi_rready), .timer_input_pin(pin_in), .timer_output_pin(pin_out),
    .match0_overflow_irq(m0), .match1_irq(m1), .capture0_irq(cp0), .capture1_irq(cp1));
  function automatic int rnd(input int lim);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % 32'(lim));
  endfunction : rnd
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, 32'h0});
    msk_q.push_back({2'h3, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] mk,
                    input logic [1:0] r = 2'h0);
    exp_q.push_back({r, d});
    msk_q.push_back({2'h3, mk});
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wait_ev(input logic sel, output int t);
    do @(negedge aclk); while ((sel ? m1 : m0) !== 1'b1);
    t = cyc;
  endtask : wait_ev
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    n_cap0 <= n_cap0 + int'(cp0 === 1'b1);
    n_cap1 <= n_cap1 + int'(cp1 === 1'b1);
    if ((bvalid && s_axi_bready) || (rvalid && s_axi_rready)) begin
      got = (rvalid && s_axi_rready) ? {rresp, rdata} : {bresp, 32'h0};
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(got & m, e)
    end
  end
  initial begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], re[i], rm[i]);
    rd(8'h2C, 32'h0, 32'hFFFFFFFF, `TEC_RESP_SLVERR);
    wr(8'h40, 32'h1, `TEC_RESP_SLVERR);
    wr(8'h28, 32'h1234);
    rd(8'h28, 32'h0, 32'hFFFF);
    $display("test reset done");
    n = 30 + rnd(32);
    a = 10 + rnd(8);
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h80);
    wr(8'h18, 32'(a));
    wr(8'h1C, 32'(n));
    wr(8'h0C, 32'h49);
    wr(8'h10, 32'h0E);
    wr(8'h04, 32'h1);
    wait_ev(1'b1, t1);
    wait_ev(1'b0, t0);
    repeat (2) @(negedge aclk);
    `CHK(pin_out, 1'b1)
    wait_ev(1'b1, t2);
    `CHK(t2 - t1, n + 1)
    `CHK(t0 - t1, a + 1)
    repeat (2) @(negedge aclk);
    `CHK(pin_out, 1'b0)
    wr(8'h18, 32'(a + 5));
    wait_ev(1'b0, t0);
    `CHK(t0 - t2, a + 1)
    wait_ev(1'b1, t1);
    wait_ev(1'b0, t0);
    `CHK(t0 - t1, a + 6)
    wr(8'h04, 32'h0);
    rd(8'h28, 32'h0, 32'hFFFF);
    rd(8'h14, 32'h0, 32'h6);
    $display("test interval and pulse done");
    wr(8'h08, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, 32'((i + 1) % 3));
      rd(8'h14, 32'(i != 1), 32'h1);
      `CHK(pin_out, 1'(i != 1))
    end
    $display("test flip-flop done");
    k = 3 + rnd(6);
    wr(8'h10, 32'h03);
    wr(8'h0C, 32'h50);
    wr(8'h04, 32'h1);
    u_pin.pulses(k, 4 + rnd(4), 5);
    repeat (8) @(posedge aclk);
    rd(8'h24, 32'(k), 32'hFFFF);
    `CHK(n_cap1, k)
    wr(8'h0C, 32'h10);
    rd(8'h20, 32'(k), 32'hFFFF);
    `CHK(n_cap0, k + 1)
    wr(8'h04, 32'h0);
    $display("test event counter done");
    wr(8'h08, 32'h01);
    wr(8'h0C, 32'h41);
    wr(8'h04, 32'h1);
    repeat (10) @(posedge aclk);
    rd(8'h14, 32'h2, 32'h6);
    rd(8'h28, 32'h0, 32'hFFFF);
    u_pin.pulses(1, 4, 4);
    rd(8'h14, 32'h4, 32'h6);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    $display("test trigger done");
    wr(8'h18, 32'hFFF0);
    wr(8'h04, 32'h1);
    wait_ev(1'b0, t0);
    wait_ev(1'b0, t1);
    `CHK(t1 - t0, 15)
    wr(8'h0C, 32'h01);
    rd(8'h20, 32'h0, 32'hFFC0);
    $display("test overflow done");
    report_and_stop();
  end
endmodule : tb_top
